// [hw/daq_control.sv]
// Digital control of the 8-bit acquisition device: mux select, conversion
// sequencing, result latch, output-converter register and bus interface.
// Assumes all pins are synchronous to clk; conv_clk is sampled, not a clock.

module daq_control (
	// Clock, enable and resets
	input wire logic clk,
	input wire logic ce,
	input wire logic reset_n,
	input wire logic power_on_n,
	// Parallel bus
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe_n,
	// Conversion control pins
	input wire logic start_trigger_n,
	input wire logic conv_clk,
	output logic busy_n,
	output logic int_n,
	// Multiplexer address
	input wire logic mux_sel_lo,
	input wire logic mux_sel_hi,
	// Analog front end
	output logic [3:0] analog_inputs,
	output logic hold,
	output logic [7:0] trial_code,
	input wire logic comp_high,
	output logic [7:0] dac_code
);

	// ----------------------------------------------------------------
	// Strobe edges
	// ----------------------------------------------------------------
	logic rd_rise, rd_fall, wr_rise, cs_rise;
	logic st_fall, cclk_fall;
	logic wr_prev_low, cs_prev_low;
	logic [7:0] data_prev;

	edge_detect u_rd (.clk(clk), .reset_n(power_on_n), .ce(ce), .level(rd_n), .rise(rd_rise), .fall(rd_fall));
	edge_detect u_wr (.clk(clk), .reset_n(power_on_n), .ce(ce), .level(wr_n), .rise(wr_rise), .fall());
	edge_detect u_cs (.clk(clk), .reset_n(power_on_n), .ce(ce), .level(cs_n), .rise(cs_rise), .fall());
	edge_detect u_st (.clk(clk), .reset_n(power_on_n), .ce(ce), .level(start_trigger_n),
		.rise(), .fall(st_fall));
	edge_detect u_cclk (.clk(clk), .reset_n(power_on_n), .ce(ce), .level(conv_clk),
		.rise(), .fall(cclk_fall));

	// The bus value one cycle back is what stood at the strobe's rising edge.
	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			data_prev <= daq_pkg::DAC_RESET;
			wr_prev_low <= 1'b0;
			cs_prev_low <= 1'b0;
		end
		else if (ce)
		begin
			data_prev <= data_bus_in;
			wr_prev_low <= ~wr_n;
			cs_prev_low <= ~cs_n;
		end
	end

	// ----------------------------------------------------------------
	// Start decoding
	// ----------------------------------------------------------------
	daq_pkg::conv_state_t state, next_state;
	logic idle, trig_start, read_start, start;

	assign idle = (state == daq_pkg::st_idle);
	assign trig_start = st_fall;
	// A read only starts when the trigger pin is parked high.
	assign read_start = rd_fall & ~cs_n & start_trigger_n;
	// Starts during a conversion are dropped; the master must wait on busy.
	assign start = idle & (trig_start | read_start);

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	logic [7:0] cnt, next_cnt;
	logic cnt_done, decide, eoc;
	logic sar_last;
	logic [7:0] sar_decided;

	assign cnt_done = (cnt == daq_pkg::DECIDE_LAST);
	// A decision is taken a fixed settle time after its clock edge.
	assign decide = ce & (state == daq_pkg::st_settle) & cnt_done;
	assign eoc = decide & sar_last;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			daq_pkg::st_idle:
			begin
				next_cnt = '0;
				if (start)
					next_state = daq_pkg::st_arm;
			end
			// Edges in this window are ignored, delaying the MSB a cycle.
			daq_pkg::st_arm:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt_done)
					next_state = daq_pkg::st_first;
			end
			// First qualifying edge only arms the MSB decision.
			daq_pkg::st_first:
			begin
				next_cnt = '0;
				if (cclk_fall)
					next_state = daq_pkg::st_edge;
			end
			daq_pkg::st_edge:
			begin
				next_cnt = '0;
				if (cclk_fall)
					next_state = daq_pkg::st_settle;
			end
			daq_pkg::st_settle:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt_done)
				begin
					next_cnt = '0;
					next_state = sar_last ? daq_pkg::st_idle : daq_pkg::st_edge;
				end
			end
			default:
			begin
				next_cnt = '0;
				next_state = daq_pkg::st_idle;
			end
		endcase
	end

	// Reset_n does not reach the sequencer, so a conversion runs through it.
	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			state <= daq_pkg::st_idle;
			cnt <= '0;
		end
		else if (ce)
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	sar_engine u_sar (
		.clk(clk),
		.reset_n(power_on_n),
		.ce(ce),
		.load(start),
		.step(decide),
		.clear(eoc),
		.comp_high(comp_high),
		.trial(trial_code),
		.decided(sar_decided),
		.last(sar_last)
	);

	// ----------------------------------------------------------------
	// Busy, hold and result latch
	// ----------------------------------------------------------------
	logic [7:0] result;

	// At 5 MHz the MSB edge plus seven more plus settle fit inside 2 us.
	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			busy_n <= 1'b1;
			hold <= 1'b0;
			result <= daq_pkg::APPROX_CLEAR;
		end
		else if (ce)
		begin
			if (start)
				busy_n <= 1'b0;
			else if (eoc)
				busy_n <= 1'b1;
			if (state == daq_pkg::st_arm && cnt_done)
				hold <= 1'b1;
			else if (eoc)
				hold <= 1'b0;
			// Only the end of conversion moves the latch, so reads meanwhile see old data.
			if (eoc)
				result <= sar_decided;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt
	// ----------------------------------------------------------------
	logic int_set, int_clr;

	assign int_set = eoc;
	assign int_clr = cs_rise | rd_rise;

	// Reset is asynchronous here and in the output-converter register; the conversion above ignores it.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			int_n <= 1'b1;
		else if (ce)
		begin
			// A completion in the clearing cycle still raises the interrupt.
			if (int_set)
				int_n <= 1'b0;
			else if (int_clr)
				int_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Output-converter register
	// ----------------------------------------------------------------
	logic dac_load;

	// The earlier of the two strobes rising ends the write.
	assign dac_load = (wr_rise & cs_prev_low) | (cs_rise & wr_prev_low);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			dac_code <= daq_pkg::DAC_RESET;
		else if (ce && dac_load)
			dac_code <= data_prev;
	end

	// ----------------------------------------------------------------
	// Multiplexer and bus drive
	// ----------------------------------------------------------------
	logic [1:0] mux_addr;
	logic [3:0] mux_onehot;

	assign mux_addr = {mux_sel_hi, mux_sel_lo};
	assign mux_onehot = 4'h1 << mux_addr;

	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
			analog_inputs <= 4'h1;
		else if (ce)
			analog_inputs <= mux_onehot;
	end

	// Result bits map straight onto the pins, bit 7 first.
	assign data_bus_out = result;
	// Drivers on only for a selected read; released otherwise.
	assign data_bus_oe_n = cs_n | rd_n;

	// ----------------------------------------------------------------
	// Check helpers
	// ----------------------------------------------------------------
	// These counters run beside the sequencer rather than reuse its count,
	// so a wrong terminal count in the sequencer cannot vouch for itself.
	// The start counter saturates; it only has to outlast one conversion.
	logic [9:0] since_start;
	logic [7:0] settle_span;
	logic [3:0] falls_taken;

	always_ff @(posedge clk or negedge power_on_n)
	begin
		if (!power_on_n)
		begin
			since_start <= '0;
			settle_span <= '0;
			falls_taken <= '0;
		end
		else if (ce)
		begin
			if (start)
				since_start <= '0;
			else if (since_start != 10'h3FF)
				since_start <= since_start + 10'h001;
			if (state == daq_pkg::st_settle)
				settle_span <= settle_span + 8'h01;
			else
				settle_span <= '0;
			if (start)
				falls_taken <= '0;
			else if (cclk_fall && (state == daq_pkg::st_first || state == daq_pkg::st_edge))
				falls_taken <= falls_taken + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!power_on_n);

	// A clock fall taken while waiting in st_edge opens a settle window counted from zero.
	// Only falls the sequencer can act on are counted by the helpers above.
	sequence s_fall_taken;
		ce && state == daq_pkg::st_edge && cclk_fall;
	endsequence

	sequence s_settle_begun;
		state == daq_pkg::st_settle && settle_span == 8'h00;
	endsequence

	mux_route_a: assert property (ce |=> analog_inputs == (4'h1 << $past(mux_addr)))
		else $error("mux select not routed");
	dac_load_a: assert property (ce && reset_n && dac_load ##1 reset_n |-> dac_code == $past(data_bus_in, 2))
		else $error("output register not loaded on write");
	read_start_a: assert property (idle && ce && rd_fall && !cs_n && start_trigger_n |=> !busy_n)
		else $error("read did not start conversion");
	trig_busy_a: assert property (idle && ce && st_fall |=> !busy_n && state == daq_pkg::st_arm)
		else $error("trigger did not start conversion");
	busy_span_a: assert property (!idle |-> !busy_n)
		else $error("busy released during conversion");
	int_clear_a: assert property (ce && int_clr && !eoc && !int_n |=> int_n)
		else $error("interrupt not cleared by strobe");
	int_reset_a: assert property (!reset_n |-> int_n && dac_code == 8'h00)
		else $error("reset did not clear interrupt and register");
	bus_result_a: assert property (!data_bus_oe_n |-> data_bus_out == result && !cs_n && !rd_n)
		else $error("bus driven outside a read");
	hold_delay_a: assert property (!idle |-> hold == (since_start >= daq_pkg::DECIDE_CYC))
		else $error("sampler not holding after start delay");
	settle_step_a: assert property (decide |-> settle_span == daq_pkg::DECIDE_LAST)
		else $error("decision settle time wrong");
	eoc_latch_a: assert property (eoc |=> result == $past(sar_decided) && !hold && !busy_n == 1'b0 && trial_code == 8'h00)
		else $error("end of conversion steps missing");
	settle_entry_a: assert property (s_fall_taken |=> s_settle_begun)
		else $error("clock fall did not open settle window");
	conv_time_a: assert property (!idle |-> since_start < daq_pkg::CONV_MAX_CYC)
		else $error("conversion longer than allowed");
	bit_count_a: assert property (eoc |-> falls_taken == daq_pkg::DATA_W + 1)
		else $error("wrong number of clock falls per conversion");
	result_hold_a: assert property (!idle && !eoc |=> $stable(result))
		else $error("result changed during conversion");

endmodule

// [hw/daq_pkg.sv]
// Constants shared by the data acquisition control logic.
// Assumes one 250 MHz system clock; every pin is already synchronous to it.
//
// Operation
// - Mux address 00,01,10,11 routes analog input A,B,C,D to the sampler.
// - Write strobe rising edge with chip select low loads the output register.
// - Read strobe falling with chip select low and start trigger high begins a conversion.
// - Start trigger falling edge begins conversion and lowers busy, chip select ignored.
// - Busy stays low for the whole conversion, released at its end.
// - Interrupt goes low at conversion end, high on chip select or read rise.
// - Reset forces interrupt high asynchronously; a running conversion continues.
// - Result is driven on the bus during read; bit 7 is most significant.
// - Result and output word are plain unsigned binary.
// - Data port is three-state, released whenever not reading.
// - With the nominal converter clock a conversion ends within 2 us.
// - Sampler switches to hold about 50 ns after the start edge.
// - MSB decided 50 ns after second qualifying falling clock edge.
// - A clock edge under 50 ns after start is ignored.
// - Remaining bits resolve 50 ns after each later edge, MSB to LSB.
// - At end: latch result, return to track, interrupt low, clear approximation.
// - In read-started mode the previous result stays on the bus meanwhile.
// - Reset clears the output-converter register to zero until the next write.
// - Output register ignores bus changes while chip select and write stay low.

package daq_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int CNT_W = 8;
	localparam logic [7:0] DAC_RESET = 8'h00;
	localparam logic [7:0] APPROX_CLEAR = 8'h00;
	localparam logic [7:0] APPROX_FIRST = 8'h80;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int DECIDE_NS = 50;
	localparam int CONV_MAX_US = 2;
	// A least time: rounded up to whole cycles.
	localparam int DECIDE_CYC = (DECIDE_NS * CLK_MHZ + 999) / 1000;
	// A longest time: rounded down.
	localparam int CONV_MAX_CYC = CONV_MAX_US * CLK_MHZ;
	localparam logic [7:0] DECIDE_LAST = 8'(DECIDE_CYC - 1);

	// ----------------------------------------------------------------
	// Conversion sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		st_idle = 5'b00001,
		st_arm = 5'b00010,
		st_first = 5'b00100,
		st_edge = 5'b01000,
		st_settle = 5'b10000
	} conv_state_t;

endpackage

// [hw/edge_detect.sv]
// Level history and edge pulses for one synchronous pin.
// Assumes the pin is already synchronous to clk.

module edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Pin
	input wire logic level,
	// Edges
	output logic rise,
	output logic fall
);

	logic prev;

	// Resets to the idle-high level that every strobe here rests at.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			prev <= 1'b1;
		else if (ce)
			prev <= level;
	end

	assign rise = ce & level & ~prev;
	assign fall = ce & ~level & prev;

endmodule

// [hw/sar_engine.sv]
// Successive-approximation register: one bit decided per step.
// Assumes the comparator answer is valid when step is raised.

module sar_engine (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic ce,
	// Control
	input wire logic load,
	input wire logic step,
	input wire logic clear,
	input wire logic comp_high,
	// Results
	output logic [7:0] trial,
	output logic [7:0] decided,
	output logic last
);

	logic [7:0] mask;

	// Keep the bit under test when the input is at or above the trial level.
	assign decided = comp_high ? trial : (trial & ~mask);
	assign last = mask[0];

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			trial <= daq_pkg::APPROX_CLEAR;
			mask <= daq_pkg::APPROX_CLEAR;
		end
		else if (ce)
		begin
			if (clear)
			begin
				trial <= daq_pkg::APPROX_CLEAR;
				mask <= daq_pkg::APPROX_CLEAR;
			end
			else if (load)
			begin
				trial <= daq_pkg::APPROX_FIRST;
				mask <= daq_pkg::APPROX_FIRST;
			end
			else if (step)
			begin
				trial <= decided | (mask >> 1);
				mask <= mask >> 1;
			end
		end
	end

endmodule

// [test/front_end_model.sv]
// Analog side of the converter: a free-running converter clock and a comparator
// that weighs the held sample of the selected channel against the trial word.
// Assumes hold rises once per conversion and analog_inputs is one-hot.

module front_end_model #(
	parameter logic [31:0] LEVELS = 32'h00000000,
	parameter int HALF = 25
) (
	// Clock
	input wire logic clk,
	// Control from the block
	input wire logic [3:0] analog_inputs,
	input wire logic hold,
	input wire logic [7:0] trial_code,
	// Answers to the block
	output logic conv_clk = 1'b1,
	output logic comp_high
);
	timeunit 1ns;
	timeprecision 1ps;
	int count = 0;
	logic [7:0] sample = 8'h00;

	// --------------------------------------------------------------
	// Converter clock
	// --------------------------------------------------------------
	// Nominal 5 MHz, left running between conversions as the part allows.
	always @(posedge clk)
	begin
		if (count == HALF - 1)
		begin
			count <= 0;
			conv_clk <= ~conv_clk;
		end
		else
			count <= count + 1;
	end

	// --------------------------------------------------------------
	// Sample and compare
	// --------------------------------------------------------------
	always @(posedge hold)
	begin
		for (int i = 0; i < 4; i++)
			if (analog_inputs[i])
				sample = LEVELS[8 * i +: 8];
	end
	assign comp_high = (sample >= trial_code);
endmodule

// [test/tb_top.sv]
// Self-checking bench for daq_control: writes, triggered conversions on every
// channel, read-started conversions on channels 2 and 1, and both resets.
// Assumes front_end_model supplies the converter clock and comparator.

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] LEVELS = 32'hA35A00FF;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic power_on_n = 1'b0;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic start_trigger_n = 1'b1;
	logic mux_sel_lo = 1'b0;
	logic mux_sel_hi = 1'b0;
	logic [7:0] host_data = 8'h00;
	logic [7:0] last_result = 8'h00;
	wire [7:0] data_bus_in;
	wire [7:0] data_bus_out;
	wire [7:0] trial_code;
	wire [7:0] dac_code;
	wire [3:0] analog_inputs;
	wire data_bus_oe_n;
	wire busy_n;
	wire int_n;
	wire hold;
	wire comp_high;
	wire conv_clk;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	always #2 clk = ~clk;
	// The pin level is the block's value while it drives, otherwise the host's.
	assign data_bus_in = data_bus_oe_n ? host_data : data_bus_out;

	daq_control daq_control_inst (.clk(clk), .ce(1'b1), .reset_n(reset_n), .power_on_n(power_on_n),
		.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
		.data_bus_oe_n(data_bus_oe_n), .start_trigger_n(start_trigger_n), .conv_clk(conv_clk),
		.busy_n(busy_n), .int_n(int_n), .mux_sel_lo(mux_sel_lo), .mux_sel_hi(mux_sel_hi),
		.analog_inputs(analog_inputs), .hold(hold), .trial_code(trial_code), .comp_high(comp_high),
		.dac_code(dac_code));
	front_end_model #(.LEVELS(LEVELS), .HALF(25)) front_end_model_inst (.clk(clk),
		.analog_inputs(analog_inputs), .hold(hold), .trial_code(trial_code), .conv_clk(conv_clk),
		.comp_high(comp_high));

	// --------------------------------------------------------------
	// Compare and report
	// --------------------------------------------------------------
	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check1(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic results();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			results();
		end
	end

	// Bounded wait for the end of a conversion; n returns the cycles spent.
	task automatic wait_busy(output int n);
		n = 0;
		while (busy_n !== 1'b1 && n < 700)
		begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic write_dac();
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		host_data <= 8'h3C;
		@(posedge clk);
		host_data <= 8'hC3;
		repeat (2) @(posedge clk);
		#1;
		check8("dac_code low strobe", 8'h00, dac_code);
		@(posedge clk);
		wr_n <= 1'b1;
		cs_n <= 1'b1;
		repeat (2) @(posedge clk);
		host_data <= 8'h11;
		#1;
		check8("dac_code written", 8'hC3, dac_code);
		@(posedge clk);
		reset_n <= 1'b0;
		#1;
		check8("dac_code reset", 8'h00, dac_code);
		@(posedge clk);
		reset_n <= 1'b1;
	endtask

	task automatic convert_trigger(input int ch, input bit rst_mid);
		int n;
		logic [7:0] exp;
		exp = LEVELS[8 * ch +: 8];
		@(posedge clk);
		{mux_sel_hi, mux_sel_lo} <= 2'(ch);
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		start_trigger_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check1("busy_n started", 1'b0, busy_n);
		check8("channel", 8'(4'b0001 << ch), 8'(analog_inputs));
		repeat (17) @(posedge clk);
		#1;
		check1("hold", 1'b1, hold);
		if (rst_mid)
		begin
			@(posedge clk);
			reset_n <= 1'b0;
			@(posedge clk);
			reset_n <= 1'b1;
		end
		wait_busy(n);
		check1("in time", 1'b1, n < 480);
		check1("int_n end", 1'b0, int_n);
		check1("hold end", 1'b0, hold);
		check8("trial_code end", 8'h00, trial_code);
		if (rst_mid)
		begin
			@(posedge clk);
			reset_n <= 1'b0;
			#1;
			check1("int_n reset", 1'b1, int_n);
			@(posedge clk);
			reset_n <= 1'b1;
		end
		// The start line stays low while the read strobe falls in trigger mode.
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		@(posedge clk);
		#1;
		check1("oe_n read", 1'b0, data_bus_oe_n);
		check8("result", exp, data_bus_out);
		@(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		start_trigger_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check1("int_n cleared", 1'b1, int_n);
		check1("oe_n idle", 1'b1, data_bus_oe_n);
		last_result = exp;
	endtask

	task automatic convert_read(input int ch);
		int n;
		logic [7:0] exp;
		exp = LEVELS[8 * ch +: 8];
		@(posedge clk);
		{mux_sel_hi, mux_sel_lo} <= 2'(ch);
		repeat (2) @(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check1("busy_n read start", 1'b0, busy_n);
		check8("old result", last_result, data_bus_out);
		wait_busy(n);
		check1("read in time", 1'b1, n < 480);
		check8("new result", exp, data_bus_out);
		@(posedge clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		last_result = exp;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		power_on_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check1("int_n after reset", 1'b1, int_n);
		check1("oe_n after reset", 1'b1, data_bus_oe_n);
		write_dac();
		for (int ch = 0; ch < 4; ch++)
			convert_trigger(ch, ch == 3);
		convert_read(2);
		convert_read(1);
		results();
	end
endmodule
